// *** verilog/vsa_pkg.sv ***
package vsa_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_FEATURE = 8'h00;
  localparam logic [7:0] ADDR_CTRL    = 8'h04;
  localparam logic [7:0] ADDR_XSE     = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0c;

  // Feature report word, second wide-vector extension flag
  localparam int          FEAT_EXT2_BIT = 5;
  localparam logic [31:0] FEAT_WORD     = 32'h0000_0001 << FEAT_EXT2_BIT;

  // Control register fields
  localparam int CTRL_AM_BIT   = 0;
  localparam int CTRL_ACF_BIT  = 1;
  localparam int CTRL_EM_BIT   = 2;
  localparam int CTRL_OSXM_BIT = 3;
  localparam int CTRL_CPL_LSB  = 4;
  localparam int CTRL_CPL_MSB  = 5;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_003f;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Extended state enable register
  localparam logic [31:0] XSE_STATE_MASK = 32'h0000_0006;
  localparam logic [31:0] XSE_RESET      = 32'h0000_0001;

  // Status register fields
  localparam int STAT_CODE_LSB = 8;
  localparam int STAT_CODE_MSB = 10;

  localparam logic [1:0] CPL_USER = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Access size codes, log2 of bytes
  localparam logic [2:0] SZ_2  = 3'h1;
  localparam logic [2:0] SZ_8  = 3'h3;
  localparam logic [2:0] SZ_16 = 3'h4;
  localparam logic [2:0] SZ_32 = 3'h5;

  localparam int NUM_VREG = 16;
  localparam int VREG_W   = 256;
  localparam int NARROW_W = 128;

  typedef enum logic [1:0] {
    CLS_NOMEM     = 2'b00,
    CLS_ALIGNED   = 2'b01,
    CLS_UNALIGNED = 2'b10,
    CLS_ARITH     = 2'b11
  } vsa_cls_e;

  typedef enum logic [2:0] {
    EXT_LEGACY = 3'b000,
    EXT_WIDE   = 3'b001,
    EXT_WIDE2  = 3'b010,
    EXT_FUSED  = 3'b011,
    EXT_HALF   = 3'b100
  } vsa_ext_e;

  typedef enum logic [2:0] {
    FLT_NONE = 3'b000,
    FLT_GP   = 3'b001,
    FLT_AC   = 3'b010,
    FLT_UD   = 3'b011,
    FLT_XM   = 3'b100
  } vsa_fault_e;

endpackage

// *** verilog/vsa_align_chk.sv ***
`timescale 1ns/1ps
module vsa_align_chk (
  input  wire logic              prefixed,
  input  wire vsa_pkg::vsa_cls_e cls,
  input  wire logic [2:0]        sz,
  input  wire logic [4:0]        addr_lo,
  input  wire logic              am,
  input  wire logic              acf,
  input  wire logic [1:0]        cpl,
  output logic                   gp,
  output logic                   ac
);

  function automatic logic misaligned(input logic [4:0] a, input logic [2:0] s);
    logic [4:0] m;
    m = 5'h1f >> (3'h5 - s);
    return |(a & m);
  endfunction

  logic mis;
  logic wide_acc;

  assign mis      = misaligned(addr_lo, sz);
  assign wide_acc = (sz == vsa_pkg::SZ_16) || (sz == vsa_pkg::SZ_32);

  always_comb begin
    gp = 1'b0;
    if (!prefixed) begin
      if (cls == vsa_pkg::CLS_ALIGNED && mis) begin
        gp = 1'b1;
      end else if (cls == vsa_pkg::CLS_ARITH && sz == vsa_pkg::SZ_16 && mis) begin
        gp = 1'b1;
      end
      // Unaligned moves never take a general-protection fault for alignment
    end else if (cls == vsa_pkg::CLS_ALIGNED && wide_acc && mis) begin
      gp = 1'b1;
    end
    // Prefixed arithmetic takes no general-protection fault at any byte alignment
  end

  // Only 2, 4 and 8 byte accesses may take an alignment check
  assign ac = !gp && mis && cls != vsa_pkg::CLS_NOMEM && !wide_acc && sz >= vsa_pkg::SZ_2
              && sz <= vsa_pkg::SZ_8 && cpl == vsa_pkg::CPL_USER && am && acf;

endmodule

// *** verilog/vsa_fp_gate.sv ***
`timescale 1ns/1ps
module vsa_fp_gate (
  input  wire vsa_pkg::vsa_ext_e ext,
  input  wire logic              is_fp,
  input  wire logic [5:0]        fp_flags,
  input  wire logic [5:0]        fp_mask,
  input  wire logic              osxm,
  output logic                   xm,
  output logic                   ud
);

  logic unmasked;

  assign unmasked = is_fp && |(fp_flags & ~fp_mask);

  always_comb begin
    xm = 1'b0;
    ud = 1'b0;
    if (ext != vsa_pkg::EXT_WIDE2 && unmasked) begin
      // Same masking for legacy, wide, fused and half-float ops
      if (osxm) begin
        xm = 1'b1;
      end else begin
        ud = 1'b1;
      end
    end
  end

endmodule

// *** verilog/vsa_fault_unit.sv ***
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module vsa_fault_unit (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]                 s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [7:0]                 s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Instruction issue
  input  wire logic                       op_valid,
  input  wire logic                       op_prefixed,
  input  wire logic                       op_vlen256,
  input  wire vsa_pkg::vsa_cls_e          op_cls,
  input  wire vsa_pkg::vsa_ext_e          op_ext,
  input  wire logic [2:0]                 op_sz,
  input  wire logic [31:0]                op_addr,
  input  wire logic                       op_is_fp,
  input  wire logic [5:0]                 op_fp_flags,
  input  wire logic [5:0]                 op_fp_mask,
  input  wire logic                       op_write,
  input  wire logic [3:0]                 op_reg,
  input  wire logic [255:0]               op_wdata,
  // Result
  output logic                            res_valid,
  output vsa_pkg::vsa_fault_e             res_fault,
  output logic [255:0]                    res_rdata
);

  logic [31:0]         ctrl_r;
  logic [31:0]         xse_r;
  logic [4:0]          sticky_r;
  logic [4:0]          sticky_nxt;
  logic [4:0]          sticky_clr;
  logic [4:0]          sticky_set;
  logic                aw_hold_r;
  logic [7:0]          awaddr_r;
  logic                w_hold_r;
  logic [31:0]         wdata_r;
  logic [3:0]          wstrb_r;
  logic                bvalid_r;
  logic [1:0]          bresp_r;
  logic                rvalid_r;
  logic [31:0]         rdata_r;
  logic [1:0]          rresp_r;
  logic                wr_fire;
  logic                res_valid_r;
  vsa_pkg::vsa_fault_e res_fault_r;
  vsa_pkg::vsa_fault_e fault_nxt;
  logic [255:0]        res_rdata_r;
  logic [255:0]        vreg_r [vsa_pkg::NUM_VREG];
  logic                am;
  logic                acf;
  logic                em;
  logic                osxm;
  logic [1:0]          cpl;
  logic                state_on;
  logic                ext_ud;
  logic                gp;
  logic                ac;
  logic                fp_xm;
  logic                fp_ud;
  logic                wr_ok;

  assign am       = ctrl_r[vsa_pkg::CTRL_AM_BIT];
  assign acf      = ctrl_r[vsa_pkg::CTRL_ACF_BIT];
  assign em       = ctrl_r[vsa_pkg::CTRL_EM_BIT];
  assign osxm     = ctrl_r[vsa_pkg::CTRL_OSXM_BIT];
  assign cpl      = ctrl_r[vsa_pkg::CTRL_CPL_MSB:vsa_pkg::CTRL_CPL_LSB];
  assign state_on = (xse_r & vsa_pkg::XSE_STATE_MASK) == vsa_pkg::XSE_STATE_MASK;

  function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // AXI4-Lite write path: address and data held separately, either order
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready  = !w_hold_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign wr_fire       = aw_hold_r && w_hold_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      awaddr_r  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_r <= 1'b0;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_r <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb_r  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= vsa_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      if (awaddr_r == vsa_pkg::ADDR_FEATURE || awaddr_r == vsa_pkg::ADDR_CTRL ||
          awaddr_r == vsa_pkg::ADDR_XSE || awaddr_r == vsa_pkg::ADDR_STATUS) begin
        bresp_r <= vsa_pkg::RESP_OKAY;
      end else begin
        bresp_r <= vsa_pkg::RESP_DECERR;
      end
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= vsa_pkg::CTRL_RESET;
    end else if (wr_fire && awaddr_r == vsa_pkg::ADDR_CTRL) begin
      ctrl_r <= merge_strb(ctrl_r, wdata_r, wstrb_r) & vsa_pkg::CTRL_WMASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xse_r <= vsa_pkg::XSE_RESET;
    end else if (wr_fire && awaddr_r == vsa_pkg::ADDR_XSE) begin
      xse_r <= merge_strb(xse_r, wdata_r, wstrb_r);
    end
  end

  // Sticky fault bits, one per fault code; write one to clear, a new event wins
  always_comb begin
    sticky_clr = 5'h00;
    sticky_set = 5'h00;
    if (wr_fire && awaddr_r == vsa_pkg::ADDR_STATUS && wstrb_r[0]) begin
      sticky_clr = wdata_r[4:0];
    end
    if (op_valid && fault_nxt != vsa_pkg::FLT_NONE) begin
      sticky_set[fault_nxt] = 1'b1;
    end
    sticky_nxt = (sticky_r & ~sticky_clr) | sticky_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sticky_r <= 5'h00;
    end else begin
      sticky_r <= sticky_nxt;
    end
  end

  // AXI4-Lite read path
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= vsa_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r  <= vsa_pkg::RESP_OKAY;
      if (s_axi_araddr == vsa_pkg::ADDR_FEATURE) begin
        rdata_r <= vsa_pkg::FEAT_WORD;
      end else if (s_axi_araddr == vsa_pkg::ADDR_CTRL) begin
        rdata_r <= ctrl_r;
      end else if (s_axi_araddr == vsa_pkg::ADDR_XSE) begin
        rdata_r <= xse_r;
      end else if (s_axi_araddr == vsa_pkg::ADDR_STATUS) begin
        rdata_r <= {21'h00_0000, res_fault_r, 3'h0, sticky_r};
      end else begin
        rdata_r <= 32'h0000_0000;
        rresp_r <= vsa_pkg::RESP_DECERR;
      end
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Fault qualification
  vsa_align_chk u_align (
    .prefixed (op_prefixed),
    .cls      (op_cls),
    .sz       (op_sz),
    .addr_lo  (op_addr[4:0]),
    .am       (am),
    .acf      (acf),
    .cpl      (cpl),
    .gp       (gp),
    .ac       (ac)
  );

  vsa_fp_gate u_fp (
    .ext      (op_ext),
    .is_fp    (op_is_fp),
    .fp_flags (op_fp_flags),
    .fp_mask  (op_fp_mask),
    .osxm     (osxm),
    .xm       (fp_xm),
    .ud       (fp_ud)
  );

  // Prefixed ops ignore the emulation bit and only check state enables
  assign ext_ud = op_prefixed ? !state_on
                              : (em && op_is_fp && op_ext == vsa_pkg::EXT_LEGACY);

  always_comb begin
    if (ext_ud) begin
      fault_nxt = vsa_pkg::FLT_UD;
    end else if (gp) begin
      fault_nxt = vsa_pkg::FLT_GP;
    end else if (ac) begin
      fault_nxt = vsa_pkg::FLT_AC;
    end else if (fp_ud) begin
      fault_nxt = vsa_pkg::FLT_UD;
    end else if (fp_xm) begin
      fault_nxt = vsa_pkg::FLT_XM;
    end else begin
      fault_nxt = vsa_pkg::FLT_NONE;
    end
  end

  // Whole-register writes are not atomic beyond one clock edge; no lock is offered
  assign wr_ok = op_valid && op_write && fault_nxt == vsa_pkg::FLT_NONE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < vsa_pkg::NUM_VREG; i++) begin
        vreg_r[i] <= 256'h0;
      end
    end else if (wr_ok) begin
      if (!op_prefixed) begin
        vreg_r[op_reg][vsa_pkg::NARROW_W-1:0] <= op_wdata[vsa_pkg::NARROW_W-1:0];
      end else if (!op_vlen256) begin
        vreg_r[op_reg] <= {128'h0, op_wdata[vsa_pkg::NARROW_W-1:0]};
      end else begin
        vreg_r[op_reg] <= op_wdata;
      end
    end
  end

  // Narrow view is the low half of the same storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_valid_r <= 1'b0;
      res_fault_r <= vsa_pkg::FLT_NONE;
      res_rdata_r <= 256'h0;
    end else begin
      res_valid_r <= op_valid;
      if (op_valid) begin
        res_fault_r <= fault_nxt;
        if (op_prefixed && op_vlen256) begin
          res_rdata_r <= vreg_r[op_reg];
        end else begin
          res_rdata_r <= {128'h0, vreg_r[op_reg][vsa_pkg::NARROW_W-1:0]};
        end
      end
    end
  end

  assign res_valid = res_valid_r;
  assign res_fault = res_fault_r;
  assign res_rdata = res_rdata_r;

  logic [255:0] prev_hi_r;
  always_ff @(posedge aclk) begin
    prev_hi_r <= vreg_r[op_reg];
  end

  legacy_gp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    op_valid && !op_prefixed && op_cls == vsa_pkg::CLS_ALIGNED && op_addr[3:0] != 4'h0
    && !(em && op_is_fp) |=> res_fault_r == vsa_pkg::FLT_GP)
    else $error("misaligned legacy aligned move did not fault");

  legacy_unal_a: assert property (@(posedge aclk) disable iff (!aresetn)
    op_valid && !op_prefixed && op_cls == vsa_pkg::CLS_UNALIGNED && !acf
    |=> res_fault_r != vsa_pkg::FLT_GP && res_fault_r != vsa_pkg::FLT_AC)
    else $error("unaligned move faulted on alignment");

  pfx_arith_a: assert property (@(posedge aclk) disable iff (!aresetn)
    op_valid && op_prefixed && op_cls == vsa_pkg::CLS_ARITH
    |=> res_fault_r != vsa_pkg::FLT_GP)
    else $error("prefixed arithmetic raised general protection");

  pfx_aligned_a: assert property (@(posedge aclk) disable iff (!aresetn)
    op_valid && op_prefixed && state_on && op_cls == vsa_pkg::CLS_ALIGNED
    && op_sz == vsa_pkg::SZ_32 && op_addr[4:0] != 5'h00
    |=> res_fault_r == vsa_pkg::FLT_GP)
    else $error("misaligned 32-byte aligned move did not fault");

  wide_no_ac_a: assert property (@(posedge aclk) disable iff (!aresetn)
    op_valid && op_sz >= vsa_pkg::SZ_16 |=> res_fault_r != vsa_pkg::FLT_AC)
    else $error("wide access took an alignment check");

  state_ud_a: assert property (@(posedge aclk) disable iff (!aresetn)
    op_valid && op_prefixed && !state_on |=> res_fault_r == vsa_pkg::FLT_UD)
    else $error("prefixed op ran with state disabled");

  upper_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    op_valid && !op_prefixed
    |=> vreg_r[$past(op_reg)][255:128] == prev_hi_r[255:128])
    else $error("legacy op changed upper bits");

  upper_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ok && op_prefixed && !op_vlen256 |=> vreg_r[$past(op_reg)][255:128] == 128'h0)
    else $error("prefixed 128-bit op kept upper bits");

  ext2_no_xm_a: assert property (@(posedge aclk) disable iff (!aresetn)
    op_valid && op_ext == vsa_pkg::EXT_WIDE2 && state_on && op_cls == vsa_pkg::CLS_NOMEM
    |=> res_fault_r == vsa_pkg::FLT_NONE)
    else $error("second extension raised a floating-point fault");

  fp_ud_a: assert property (@(posedge aclk) disable iff (!aresetn)
    op_valid && fp_ud && !ext_ud && !gp && !ac |=> res_fault_r == vsa_pkg::FLT_UD)
    else $error("unmasked fp exception without handler not undefined opcode");

endmodule

// *** tb/vsa_issue_model.sv ***
`timescale 1ns/1ps
module vsa_issue_model (
  input  wire logic                aclk,
  output logic                     op_valid,
  output logic                     op_prefixed,
  output logic                     op_vlen256,
  output vsa_pkg::vsa_cls_e        op_cls,
  output vsa_pkg::vsa_ext_e        op_ext,
  output logic [2:0]               op_sz,
  output logic [31:0]              op_addr,
  output logic                     op_is_fp,
  output logic [5:0]               op_fp_flags,
  output logic [5:0]               op_fp_mask,
  output logic                     op_write,
  output logic [3:0]               op_reg,
  output logic [255:0]             op_wdata,
  input  wire logic                res_valid,
  input  wire vsa_pkg::vsa_fault_e res_fault,
  input  wire logic [255:0]        res_rdata
);
  initial begin
    {op_valid, op_prefixed, op_vlen256, op_is_fp, op_write} = 5'h00;
    op_cls = vsa_pkg::CLS_NOMEM;
    op_ext = vsa_pkg::EXT_LEGACY;
    {op_sz, op_addr, op_fp_flags, op_fp_mask, op_reg, op_wdata} = '0;
  end

  // Fields flip once the op is taken, so logic that samples late sees garbage
  task automatic issue(input logic p, input logic v, input vsa_pkg::vsa_cls_e c,
                       input vsa_pkg::vsa_ext_e e, input logic [2:0] s,
                       input logic [4:0] a, input logic fp, input logic [5:0] fl,
                       input logic [5:0] mk, input logic w, input logic [3:0] r,
                       input logic [255:0] d, output logic ok,
                       output vsa_pkg::vsa_fault_e f, output logic [255:0] q);
    @(posedge aclk);
    op_valid    <= 1'b1;
    op_prefixed <= p;
    op_vlen256  <= v;
    op_cls      <= c;
    op_ext      <= e;
    op_sz       <= s;
    op_addr     <= {27'h123_4567, a};
    op_is_fp    <= fp;
    op_fp_flags <= fl;
    op_fp_mask  <= mk;
    op_write    <= w;
    op_reg      <= r;
    op_wdata    <= d;
    @(posedge aclk);
    op_valid <= 1'b0;
    op_write <= ~w;
    op_addr  <= ~op_addr;
    op_reg   <= ~r;
    op_wdata <= ~d;
    @(posedge aclk);
    ok = res_valid;
    f  = res_fault;
    q  = res_rdata;
  endtask
endmodule

// *** tb/vsa_fault_unit_bench.sv ***
`timescale 1ns/1ps
module vsa_fault_unit_bench;
  logic                aclk, aresetn, op_valid, op_prefixed, op_vlen256, op_is_fp, op_write;
  logic [7:0]          s_axi_awaddr, s_axi_araddr;
  logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                s_axi_rvalid, s_axi_rready, res_valid;
  logic [31:0]         s_axi_wdata, s_axi_rdata, op_addr;
  logic [3:0]          s_axi_wstrb, op_reg;
  logic [1:0]          s_axi_bresp, s_axi_rresp;
  logic [2:0]          op_sz;
  logic [5:0]          op_fp_flags, op_fp_mask;
  logic [255:0]        op_wdata, res_rdata, last_q;
  vsa_pkg::vsa_cls_e   op_cls;
  vsa_pkg::vsa_ext_e   op_ext;
  vsa_pkg::vsa_fault_e res_fault;
  int                  num_errors = 0, comparisons = 0;
  localparam logic [127:0] VZ = '0;
  localparam logic [127:0] VHI = {8{16'haaaa}};
  localparam logic [127:0] VLO = {8{16'h1111}};
  localparam logic [127:0] VB = {8{16'h5a5a}};
  localparam logic [127:0] VC = {8{16'hc3c3}};

  vsa_fault_unit u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .op_valid, .op_prefixed, .op_vlen256,
    .op_cls, .op_ext, .op_sz, .op_addr, .op_is_fp, .op_fp_flags, .op_fp_mask, .op_write,
    .op_reg, .op_wdata, .res_valid, .res_fault, .res_rdata);
  vsa_issue_model u_issue (.aclk, .op_valid, .op_prefixed, .op_vlen256, .op_cls, .op_ext,
    .op_sz, .op_addr, .op_is_fp, .op_fp_flags, .op_fp_mask, .op_write, .op_reg,
    .op_wdata, .res_valid, .res_fault, .res_rdata);

  always #50 aclk = ~aclk;

  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_flt(input string n, input vsa_pkg::vsa_fault_e e,
                         input vsa_pkg::vsa_fault_e g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_vec(input string n, input logic [255:0] e, input logic [255:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk_word("bresp", 32'(er), 32'(r));
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk_word("rdata", e, d);
    chk_word("rresp", 32'(er), 32'(r));
  endtask

  task automatic go(input logic p, input logic v, input vsa_pkg::vsa_cls_e c,
                    input vsa_pkg::vsa_ext_e e, input logic [2:0] s, input logic [4:0] a,
                    input logic fp, input logic [5:0] fl, input logic [5:0] mk,
                    input logic w, input logic [255:0] d, input vsa_pkg::vsa_fault_e ef);
    logic                ok;
    vsa_pkg::vsa_fault_e f;
    u_issue.issue(p, v, c, e, s, a, fp, fl, mk, w, 4'h2, d, ok, f, last_q);
    chk_word("res_valid", 32'h0000_0001, {31'h0000_0000, ok});
    chk_flt("res_fault", ef, f);
  endtask
  task automatic mo(input logic p, input vsa_pkg::vsa_cls_e c, input logic [2:0] s,
                    input logic [4:0] a, input vsa_pkg::vsa_fault_e ef);
    go(p, 1'b0, c, vsa_pkg::vsa_ext_e'({2'b00, p}), s, a, 1'b0, 6'h00, 6'h00, 1'b0, '0, ef);
  endtask
  task automatic fo(input vsa_pkg::vsa_ext_e e, input logic [5:0] fl, input logic [5:0] mk,
                    input vsa_pkg::vsa_fault_e ef);
    go(e != vsa_pkg::EXT_LEGACY, 1'b0, vsa_pkg::CLS_NOMEM, e, vsa_pkg::SZ_16, 5'h00, 1'b1,
       fl, mk, 1'b0, '0, ef);
  endtask
  task automatic ro(input logic p, input logic v, input logic w, input logic [255:0] d);
    go(p, v, vsa_pkg::CLS_NOMEM, vsa_pkg::vsa_ext_e'({2'b00, p}), vsa_pkg::SZ_16, 5'h00,
       1'b0, 6'h00, 6'h00, w, d, vsa_pkg::FLT_NONE);
  endtask

  task automatic t_regs;
    rd_chk(vsa_pkg::ADDR_FEATURE, 32'h0000_0020, vsa_pkg::RESP_OKAY);
    rd_chk(vsa_pkg::ADDR_CTRL, 32'h0000_0000, vsa_pkg::RESP_OKAY);
    rd_chk(vsa_pkg::ADDR_STATUS, 32'h0000_0000, vsa_pkg::RESP_OKAY);
    wr(vsa_pkg::ADDR_FEATURE, 32'h0000_0000, vsa_pkg::RESP_OKAY);
    rd_chk(vsa_pkg::ADDR_FEATURE, 32'h0000_0020, vsa_pkg::RESP_OKAY);
    wr(8'h40, 32'hffff_ffff, vsa_pkg::RESP_DECERR);
    rd_chk(8'h40, 32'h0000_0000, vsa_pkg::RESP_DECERR);
  endtask
  task automatic t_state;
    rd_chk(vsa_pkg::ADDR_XSE, 32'h0000_0001, vsa_pkg::RESP_OKAY);
    for (int i = 1; i < 5; i++) begin
      go(1'b1, 1'b0, vsa_pkg::CLS_NOMEM, vsa_pkg::vsa_ext_e'(i[2:0]), vsa_pkg::SZ_16, 5'h00,
         1'b0, 6'h00, 6'h00, 1'b0, '0, vsa_pkg::FLT_UD);
    end
    wr(vsa_pkg::ADDR_XSE, 32'h0000_0005, vsa_pkg::RESP_OKAY);
    mo(1'b1, vsa_pkg::CLS_NOMEM, vsa_pkg::SZ_16, 5'h00, vsa_pkg::FLT_UD);
    wr(vsa_pkg::ADDR_XSE, 32'h0000_0007, vsa_pkg::RESP_OKAY);
    rd_chk(vsa_pkg::ADDR_XSE, 32'h0000_0007, vsa_pkg::RESP_OKAY);
    mo(1'b1, vsa_pkg::CLS_NOMEM, vsa_pkg::SZ_16, 5'h00, vsa_pkg::FLT_NONE);
  endtask
  task automatic t_align;
    mo(1'b0, vsa_pkg::CLS_ALIGNED, vsa_pkg::SZ_16, 5'h08, vsa_pkg::FLT_GP);
    mo(1'b0, vsa_pkg::CLS_ALIGNED, vsa_pkg::SZ_16, 5'h10, vsa_pkg::FLT_NONE);
    mo(1'b0, vsa_pkg::CLS_UNALIGNED, vsa_pkg::SZ_16, 5'h01, vsa_pkg::FLT_NONE);
    mo(1'b0, vsa_pkg::CLS_ARITH, vsa_pkg::SZ_16, 5'h04, vsa_pkg::FLT_GP);
    mo(1'b1, vsa_pkg::CLS_ARITH, vsa_pkg::SZ_32, 5'h03, vsa_pkg::FLT_NONE);
    mo(1'b1, vsa_pkg::CLS_ARITH, vsa_pkg::SZ_16, 5'h09, vsa_pkg::FLT_NONE);
    mo(1'b1, vsa_pkg::CLS_ALIGNED, vsa_pkg::SZ_32, 5'h10, vsa_pkg::FLT_GP);
    mo(1'b1, vsa_pkg::CLS_ALIGNED, vsa_pkg::SZ_16, 5'h18, vsa_pkg::FLT_GP);
    mo(1'b1, vsa_pkg::CLS_ALIGNED, vsa_pkg::SZ_16, 5'h10, vsa_pkg::FLT_NONE);
  endtask
  task automatic t_acheck;
    logic [31:0] cv [3] = '{32'h0000_0023, 32'h0000_0031, 32'h0000_0032};
    wr(vsa_pkg::ADDR_CTRL, 32'h0000_0033, vsa_pkg::RESP_OKAY);
    wr(vsa_pkg::ADDR_STATUS, 32'h0000_001f, vsa_pkg::RESP_OKAY);
    mo(1'b0, vsa_pkg::CLS_UNALIGNED, vsa_pkg::SZ_8, 5'h04, vsa_pkg::FLT_AC);
    rd_chk(vsa_pkg::ADDR_STATUS, 32'h0000_0204, vsa_pkg::RESP_OKAY);
    mo(1'b1, vsa_pkg::CLS_UNALIGNED, 3'h2, 5'h02, vsa_pkg::FLT_AC);
    mo(1'b1, vsa_pkg::CLS_UNALIGNED, vsa_pkg::SZ_2, 5'h03, vsa_pkg::FLT_AC);
    mo(1'b1, vsa_pkg::CLS_UNALIGNED, vsa_pkg::SZ_8, 5'h08, vsa_pkg::FLT_NONE);
    mo(1'b1, vsa_pkg::CLS_UNALIGNED, vsa_pkg::SZ_16, 5'h01, vsa_pkg::FLT_NONE);
    mo(1'b1, vsa_pkg::CLS_ARITH, vsa_pkg::SZ_32, 5'h04, vsa_pkg::FLT_NONE);
    foreach (cv[i]) begin
      wr(vsa_pkg::ADDR_CTRL, cv[i], vsa_pkg::RESP_OKAY);
      mo(1'b0, vsa_pkg::CLS_UNALIGNED, vsa_pkg::SZ_8, 5'h04, vsa_pkg::FLT_NONE);
    end
  endtask
  task automatic t_fp;
    vsa_pkg::vsa_ext_e xe [4] = '{vsa_pkg::EXT_LEGACY, vsa_pkg::EXT_WIDE, vsa_pkg::EXT_FUSED,
                                  vsa_pkg::EXT_HALF};
    wr(vsa_pkg::ADDR_CTRL, 32'h0000_0000, vsa_pkg::RESP_OKAY);
    fo(vsa_pkg::EXT_WIDE, 6'h01, 6'h00, vsa_pkg::FLT_UD);
    fo(vsa_pkg::EXT_WIDE, 6'h01, 6'h01, vsa_pkg::FLT_NONE);
    fo(vsa_pkg::EXT_WIDE2, 6'h01, 6'h00, vsa_pkg::FLT_NONE);
    wr(vsa_pkg::ADDR_CTRL, 32'h0000_0008, vsa_pkg::RESP_OKAY);
    foreach (xe[i]) fo(xe[i], 6'h10, 6'h0f, vsa_pkg::FLT_XM);
    fo(vsa_pkg::EXT_FUSED, 6'h10, 6'h10, vsa_pkg::FLT_NONE);
    fo(vsa_pkg::EXT_WIDE2, 6'h3f, 6'h00, vsa_pkg::FLT_NONE);
    wr(vsa_pkg::ADDR_CTRL, 32'h0000_000c, vsa_pkg::RESP_OKAY);
    fo(vsa_pkg::EXT_WIDE, 6'h00, 6'h00, vsa_pkg::FLT_NONE);
    fo(vsa_pkg::EXT_LEGACY, 6'h00, 6'h00, vsa_pkg::FLT_UD);
    wr(vsa_pkg::ADDR_CTRL, 32'h0000_0000, vsa_pkg::RESP_OKAY);
  endtask
  task automatic t_vregs;
    ro(1'b1, 1'b1, 1'b1, {VHI, VLO});
    ro(1'b0, 1'b0, 1'b0, '0);
    chk_vec("res_rdata", {VZ, VLO}, last_q);
    ro(1'b0, 1'b0, 1'b1, {VC, VB});
    ro(1'b1, 1'b1, 1'b0, '0);
    chk_vec("res_rdata", {VHI, VB}, last_q);
    ro(1'b1, 1'b0, 1'b1, {VB, VC});
    ro(1'b1, 1'b1, 1'b0, '0);
    chk_vec("res_rdata", {VZ, VC}, last_q);
    go(1'b0, 1'b0, vsa_pkg::CLS_ALIGNED, vsa_pkg::EXT_LEGACY, vsa_pkg::SZ_16, 5'h08, 1'b0,
       6'h00, 6'h00, 1'b1, {VHI, VHI}, vsa_pkg::FLT_GP);
    ro(1'b1, 1'b1, 1'b0, '0);
    chk_vec("res_rdata", {VZ, VC}, last_q);
  endtask

  task automatic close_out;
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_state;
    t_align;
    t_acheck;
    t_fp;
    t_vregs;
    close_out;
  end

  // About 210 cycles of traffic; the margin covers slow handshakes
  initial begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    close_out;
  end
endmodule
